// ### rtl/psd_top.sv
// Functional notes
// - scan converts both battery and auxiliary inputs
// - scan end leaves newest value per result
// - one start write runs all four
// - scan time follows the documented formula
// - eight-bit code sets output sink current
// - control bit powers the converter up/down
// - average count zero treated as one
`timescale 1ns/10ps
`default_nettype none
`include "psd_cfg.svh"
module psd_top
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic scan_start_i,
	input wire logic [`PSD_AVG_W-1:0] average_count_i,
	input wire logic [`PSD_CNT_W-1:0] bits_cycles_i,
	input wire logic [`PSD_CNT_W-1:0] ref_cycles_i,
	input wire logic dac_wr_i,
	input wire logic [`PSD_DAC_W-1:0] dac_data_i,
	input wire logic dac_pwr_wr_i,
	input wire logic dac_pwr_i,
	input wire logic adc_done_i,
	input wire logic [`PSD_RES_W-1:0] adc_data_i,
	output logic adc_start_o,
	output logic [1:0] adc_chan_o,
	output logic scan_busy_o,
	output logic scan_done_o,
	output logic [`PSD_NCH*`PSD_RES_W-1:0] results_o,
	output logic [`PSD_DAC_W-1:0] dac_code_o,
	output logic dac_pwr_o
);
	////////////////////////////////////////////////////////////////
	// reset release synchroniser
	logic rst_s1_reg;
	logic rst_n;
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end
	////////////////////////////////////////////////////////////////
	// sequencer state
	psd_pkg::psd_state_t state_reg;
	psd_pkg::psd_chan_t chan_reg;
	logic [`PSD_CNT_W-1:0] cnt_reg;
	logic [`PSD_AVG_W-1:0] avg_reg;
	logic [`PSD_AVG_W-1:0] avg_left_reg;
	logic [`PSD_CNT_W-1:0] ref_reg;
	logic [`PSD_CNT_W-1:0] bits_reg;
	logic res_wr;
	psd_conv_if cif();
	// result is latched on the converter answer for the current input
	assign res_wr = (state_reg == psd_pkg::PSD_ST_CONV) && adc_done_i;
	assign cif.start = adc_start_o;
	assign cif.chan = chan_reg;
	assign cif.done = res_wr;
	assign cif.data = adc_data_i;
	// scan sequencer: fixed, reference, then per input average x (conversion until adc_done_i + overhead)
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= psd_pkg::PSD_ST_IDLE;
			chan_reg <= psd_pkg::PSD_CH_BAT1;
			cnt_reg <= '0;
			avg_reg <= '0;
			avg_left_reg <= '0;
			ref_reg <= '0;
			bits_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				psd_pkg::PSD_ST_IDLE:
				begin
					if (scan_start_i)
					begin
						// zero means no averaging
						avg_reg <= (average_count_i == '0) ? `PSD_AVG_W'(1) : average_count_i;
						ref_reg <= ref_cycles_i;
						bits_reg <= bits_cycles_i;
						chan_reg <= psd_pkg::PSD_CH_BAT1;
						cnt_reg <= `PSD_CNT_W'(`PSD_SCAN_FIXED_CYC - 1);
						state_reg <= psd_pkg::PSD_ST_FIX;
					end
				end
				psd_pkg::PSD_ST_FIX:
				begin
					if (cnt_reg == '0)
					begin
						cnt_reg <= ref_reg;
						state_reg <= psd_pkg::PSD_ST_REF;
					end
					else
						cnt_reg <= cnt_reg - 1'b1;
				end
				psd_pkg::PSD_ST_REF:
				begin
					if (cnt_reg == '0)
					begin
						avg_left_reg <= avg_reg;
						state_reg <= psd_pkg::PSD_ST_CONV;
					end
					else
						cnt_reg <= cnt_reg - 1'b1;
				end
				psd_pkg::PSD_ST_CONV:
				begin
					// conversion lasts until the answer on adc_done_i; bits_cycles_i is latched but not counted
					if (adc_done_i)
					begin
						cnt_reg <= `PSD_CNT_W'(`PSD_CONV_OVH_CYC - 1);
						state_reg <= psd_pkg::PSD_ST_OVH;
					end
				end
				psd_pkg::PSD_ST_OVH:
				begin
					if (cnt_reg != '0)
						cnt_reg <= cnt_reg - 1'b1;
					else if (avg_left_reg > `PSD_AVG_W'(1))
					begin
						avg_left_reg <= avg_left_reg - 1'b1;
						state_reg <= psd_pkg::PSD_ST_CONV;
					end
					else if (chan_reg == psd_pkg::PSD_CH_AUX2)
						state_reg <= psd_pkg::PSD_ST_IDLE;
					else
					begin
						// next input in fixed order
						chan_reg <= psd_pkg::psd_chan_t'(chan_reg + 2'b01);
						avg_left_reg <= avg_reg;
						state_reg <= psd_pkg::PSD_ST_CONV;
					end
				end
				default:
					state_reg <= psd_pkg::PSD_ST_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// converter request: one-cycle pulse on entry to conversion
	logic conv_entry;
	assign conv_entry = (state_reg == psd_pkg::PSD_ST_REF && cnt_reg == '0)
		|| (state_reg == psd_pkg::PSD_ST_OVH && cnt_reg == '0
		&& !(avg_left_reg <= `PSD_AVG_W'(1) && chan_reg == psd_pkg::PSD_CH_AUX2));
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			adc_start_o <= 1'b0;
		else
			adc_start_o <= conv_entry;
	end
	// channel and status outputs
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			adc_chan_o <= 2'b00;
			scan_busy_o <= 1'b0;
			scan_done_o <= 1'b0;
		end
		else
		begin
			adc_chan_o <= (state_reg == psd_pkg::PSD_ST_OVH && cnt_reg == '0
				&& avg_left_reg <= `PSD_AVG_W'(1) && chan_reg != psd_pkg::PSD_CH_AUX2)
				? 2'(chan_reg + 2'b01) : chan_reg;
			scan_busy_o <= (state_reg != psd_pkg::PSD_ST_IDLE) || scan_start_i;
			scan_done_o <= state_reg == psd_pkg::PSD_ST_OVH && cnt_reg == '0
				&& avg_left_reg <= `PSD_AVG_W'(1) && chan_reg == psd_pkg::PSD_CH_AUX2;
		end
	end
	////////////////////////////////////////////////////////////////
	// result registers (last answer per input stands, no averaging)
	psd_result_bank u_bank
	(
		.clk_i(sys_clk_i),
		.rst_n_i(rst_n),
		.wr_i(cif.done),
		.chan_i(cif.chan),
		.data_i(cif.data),
		.res_o(results_o)
	);
	////////////////////////////////////////////////////////////////
	// d/a data and power control
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			dac_code_o <= `PSD_DAC_RST;
		else if (dac_wr_i)
			dac_code_o <= dac_data_i;
	end
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			dac_pwr_o <= 1'b0;
		else if (dac_pwr_wr_i)
			dac_pwr_o <= dac_pwr_i;
	end
endmodule
`default_nettype wire

// ### inc/psd_cfg.svh
`ifndef PSD_CFG_SVH
`define PSD_CFG_SVH
// scan timing in nanoseconds, as printed
`define PSD_SCAN_FIXED_NS 7500
`define PSD_CONV_OVH_NS 4400
`define PSD_CLK_NS 4
// derived cycle counts, rounded up (least times)
`define PSD_SCAN_FIXED_CYC ((`PSD_SCAN_FIXED_NS + `PSD_CLK_NS - 1) / `PSD_CLK_NS)
`define PSD_CONV_OVH_CYC ((`PSD_CONV_OVH_NS + `PSD_CLK_NS - 1) / `PSD_CLK_NS)
`define PSD_CNT_W 16
`define PSD_RES_W 12
`define PSD_DAC_W 8
`define PSD_DAC_RST 8'h00
`define PSD_NCH 4
`define PSD_AVG_W 4
`endif

// ### inc/psd_pkg.sv
package psd_pkg;
	typedef enum logic [1:0]
	{
		PSD_CH_BAT1 = 2'b00,
		PSD_CH_BAT2 = 2'b01,
		PSD_CH_AUX1 = 2'b10,
		PSD_CH_AUX2 = 2'b11
	} psd_chan_t;
	typedef enum logic [2:0]
	{
		PSD_ST_IDLE = 3'b000,
		PSD_ST_FIX = 3'b001,
		PSD_ST_REF = 3'b010,
		PSD_ST_CONV = 3'b011,
		PSD_ST_OVH = 3'b100
	} psd_state_t;
endpackage

// ### inc/psd_conv_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "psd_cfg.svh"
// request/answer pair between scan sequencer and converter front end
interface psd_conv_if;
	logic start;
	psd_pkg::psd_chan_t chan;
	logic done;
	logic [`PSD_RES_W-1:0] data;
	modport seq (output start, output chan, input done, input data);
	modport adc (input start, input chan, output done, output data);
endinterface
`default_nettype wire

// ### rtl/psd_result_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "psd_cfg.svh"
// holds the newest result for each scanned input
module psd_result_bank
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_i,
	input wire psd_pkg::psd_chan_t chan_i,
	input wire logic [`PSD_RES_W-1:0] data_i,
	output logic [`PSD_NCH*`PSD_RES_W-1:0] res_o
);
	genvar g;
	generate
		for (g = 0; g < `PSD_NCH; g++)
		begin : g_res
			// one result register per input
			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					res_o[g*`PSD_RES_W +: `PSD_RES_W] <= '0;
				else if (wr_i && (chan_i == psd_pkg::psd_chan_t'(g)))
					res_o[g*`PSD_RES_W +: `PSD_RES_W] <= data_i;
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### sim/psd_top_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "psd_cfg.svh"
// watches the scan sequencer and converter control at the top ports
module psd_top_props
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic scan_start_i,
	input wire logic [`PSD_CNT_W-1:0] ref_cycles_i,
	input wire logic dac_wr_i,
	input wire logic [`PSD_DAC_W-1:0] dac_data_i,
	input wire logic dac_pwr_wr_i,
	input wire logic dac_pwr_i,
	input wire logic adc_start_o,
	input wire logic [1:0] adc_chan_o,
	input wire logic scan_busy_o,
	input wire logic scan_done_o,
	input wire logic [`PSD_DAC_W-1:0] dac_code_o,
	input wire logic dac_pwr_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	logic [15:0] cyc_reg;
	// cycles since the last accepted start, saturating
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			cyc_reg <= 16'h0000;
		else if (scan_start_i && !scan_busy_o)
			cyc_reg <= 16'h0000;
		else if (cyc_reg != 16'hFFFF)
			cyc_reg <= cyc_reg + 16'h0001;
	end
	a_start_sets_busy: assert property (scan_start_i && !scan_busy_o |=> scan_busy_o)
		else $error("busy missing");
	a_idle_no_conv: assert property (!scan_busy_o |-> !adc_start_o)
		else $error("request while idle");
	a_conv_not_early: assert property (adc_start_o |-> cyc_reg >= ref_cycles_i + `PSD_SCAN_FIXED_CYC)
		else $error("request too early");
	a_chan_in_order: assert property (scan_busy_o && $past(scan_busy_o)
		|-> $stable(adc_chan_o) || adc_chan_o == $past(adc_chan_o) + 2'h1)
		else $error("channel order");
	a_end_to_idle: assert property (scan_done_o |-> ##2 !scan_busy_o)
		else $error("no idle after scan");
	a_dac_code_load: assert property (dac_wr_i |=> dac_code_o == $past(dac_data_i))
		else $error("code not loaded");
	a_dac_code_hold: assert property (!dac_wr_i |=> $stable(dac_code_o))
		else $error("code changed");
	a_dac_pwr_load: assert property (dac_pwr_wr_i |=> dac_pwr_o == $past(dac_pwr_i))
		else $error("power not loaded");
	c_scan_done: cover property (scan_done_o);
	c_last_chan: cover property (adc_start_o && adc_chan_o == 2'h3);
	c_busy_start: cover property (scan_busy_o && scan_start_i);
endmodule
bind psd_top psd_top_props chk_u (.*);
`default_nettype wire

// ### sim/psd_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
// converter front end: answers each request after LAT cycles with a tagged value
module psd_adc_model #(parameter int LAT = 3)
(
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [1:0] chan_i,
	output logic done_o = 1'b0,
	output logic [11:0] data_o
);
	int wait_reg = 0;
	logic [7:0] seq_reg = 8'h00;
	logic [11:0] val_reg = 12'h000;
	// value only valid with done, the inverse stands otherwise
	assign data_o = done_o ? val_reg : ~val_reg;
	// count down the conversion, then answer once
	always @(posedge clk_i)
	begin
		done_o <= 1'b0;
		if (start_i)
		begin
			wait_reg <= LAT;
			val_reg <= {chan_i, 2'b01, seq_reg};
		end
		else if (wait_reg == 1)
		begin
			wait_reg <= 0;
			done_o <= 1'b1;
			seq_reg <= seq_reg + 8'h01;
		end
		else if (wait_reg > 1)
			wait_reg <= wait_reg - 1;
	end
endmodule
`default_nettype wire

// ### sim/port_scan_and_dac_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module port_scan_and_dac_control_tb;
	typedef struct {logic [3:0] avg; logic [15:0] rf; logic [7:0] code; logic pwr;} psd_row_t;
	logic sys_clk_i = 1'b0, rstn_i = 1'b0, scan_start_i = 1'b0, dac_wr_i = 1'b0;
	logic dac_pwr_wr_i = 1'b0, dac_pwr_i = 1'b0, adc_start_o, adc_done_i, scan_busy_o;
	logic scan_done_o, dac_pwr_o;
	logic [3:0] average_count_i = 4'h0;
	logic [15:0] ref_cycles_i = 16'h0000, bits_cycles_i = 16'h000C;
	logic [7:0] dac_data_i = 8'h00, dac_code_o;
	logic [1:0] adc_chan_o;
	logic [11:0] adc_data_i;
	logic [47:0] results_o, exp_res;
	int n_mismatch = 0, tests_run = 0, k = 0;
	psd_row_t rows [3] = '{'{4'h0, 16'h0000, 8'hFF, 1'b1}, '{4'h2, 16'h0005, 8'h00, 1'b0},
		'{4'h1, 16'h0000, 8'hA5, 1'b1}};
	psd_top dut_u (.*);
	psd_adc_model #(.LAT(3)) adc_u (.clk_i(sys_clk_i), .start_i(adc_start_o),
		.chan_i(adc_chan_o), .done_o(adc_done_i), .data_o(adc_data_i));
	initial forever #2 sys_clk_i = ~sys_clk_i;
	////////////////////////////////////////////////////////////////////////////////
	task chk(string name, logic [63:0] exp, logic [63:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", name, exp, got);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one scan; again pulses a second start while busy, which must be ignored
	task scan(logic [3:0] avg, logic [15:0] rf, bit again);
		int a, lim, t;
		a = (avg == 4'h0) ? 1 : avg;
		lim = 1875 + rf + 4 * a * 1100;
		@(negedge sys_clk_i) scan_start_i = 1'b1;
		average_count_i = avg;
		ref_cycles_i = rf;
		for (t = 1; scan_done_o !== 1'b1 && t < lim + 4 * a * 7 + 20; t++)
			@(negedge sys_clk_i) scan_start_i = again && t == 100;
		// a scan that never ends runs out of loop and must not count as on time
		chk("scan_time", 1, scan_done_o === 1'b1 && t >= lim && t <= lim + 4 * a * 7 + 20);
		for (int c = 0; c < 4; c++)
			exp_res[c*12 +: 12] = {2'(c), 2'b01, 8'(k + (c + 1) * a - 1)};
		k += 4 * a;
		@(negedge sys_clk_i) chk("results", exp_res, results_o);
		chk("busy", 0, scan_busy_o);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(negedge sys_clk_i);
		rstn_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		foreach (rows[i])
		begin
			{dac_wr_i, dac_pwr_wr_i, dac_data_i, dac_pwr_i} = {2'b11, rows[i].code, rows[i].pwr};
			@(negedge sys_clk_i) {dac_wr_i, dac_pwr_wr_i} = 2'b00;
			chk("dac", {rows[i].code, rows[i].pwr}, {dac_code_o, dac_pwr_o});
			scan(rows[i].avg, rows[i].rf, 1'b0);
		end
		scan(4'h3, 16'h0000, 1'b1);
		// reset in mid-scan clears busy, d/a code, d/a power and results
		@(negedge sys_clk_i) scan_start_i = 1'b1;
		@(negedge sys_clk_i) scan_start_i = 1'b0;
		repeat (3000) @(negedge sys_clk_i);
		rstn_i = 1'b0;
		@(negedge sys_clk_i) chk("reset", 0, {scan_busy_o, dac_code_o, dac_pwr_o, results_o});
		report_and_stop;
	end
	// watchdog well beyond the expected run length
	initial
	begin
		#240000;
		n_mismatch++;
		report_and_stop;
	end
endmodule
`default_nettype wire
